// ===== sbc_defines.vh
// Constants for the status and bin command handler
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH
// Command opcodes
`define SBC_OP_CLS        4'h0
`define SBC_OP_ESE_W      4'h1
`define SBC_OP_ESE_R      4'h2
`define SBC_OP_ESR_R      4'h3
`define SBC_OP_SRE_W      4'h4
`define SBC_OP_SRE_R      4'h5
`define SBC_OP_SUM_R      4'h6
`define SBC_OP_TRG        4'h7
`define SBC_OP_JBEEP_W    4'h8
`define SBC_OP_JBEEP_R    4'h9
`define SBC_OP_KBEEP_W    4'hA
`define SBC_OP_KBEEP_R    4'hB
`define SBC_OP_BIN_W      4'hC
`define SBC_OP_BIN_R      4'hD
`define SBC_OP_DISP_W     4'hE
`define SBC_OP_DISP_R     4'hF
// Limit opcodes share a separate strobe
`define SBC_LIM_CNT       1'b0
`define SBC_LIM_DEV       1'b1
// Standard event bit positions
`define SBC_EV_PON        7
`define SBC_EV_URQ        6
`define SBC_EV_CME        5
`define SBC_EV_EXE        4
`define SBC_EV_DDE        3
`define SBC_EV_QYE        2
`define SBC_EV_RQC        1
`define SBC_EV_OPC        0
// Status byte bit positions
`define SBC_SB_MSS        6
`define SBC_SB_ESB        5
`define SBC_SB_MAV        4
// Keep mask for service request enable (bits 6,7 dropped)
`define SBC_SRE_KEEP      8'h3F
`define SBC_NEVER_SET     8'h42
// Judgment beep encodings
`define SBC_JB_IN         2'h0
`define SBC_JB_OUT        2'h1
`define SBC_JB_OFF        2'h2
`define SBC_JB_SPARE      2'h3
// Sub-display encodings (bin numbers 1..14 use their value)
`define SBC_DS_OFF        4'h0
`define SBC_DS_BIN_MAX    4'hE
`define SBC_DS_SECOND     4'hF
`define SBC_DSK_BIN       2'h0
`define SBC_DSK_REF1      2'h1
`define SBC_DSK_REF2      2'h2
`define SBC_DSK_OTHER     2'h3
// Limit storage
`define SBC_BIN_MIN       4'h1
`define SBC_BIN_MAX       4'hE
`define SBC_CNT_MAX       20'hF_423F
`define SBC_DEV_MAX       18'sh1_869F
`define SBC_DEV_MIN       -18'sh1_869F
`define SBC_CNT_HI        19
`define SBC_DEV_HI        17
`define SBC_LIM_W         21
`define SBC_LIM_OFF_BIT   20
`define SBC_ZERO8         8'h00
`define SBC_ZERO21        21'h00_0000
`endif

// ===== sbc_status_bin.v
// Status register and bin settings command handler
`timescale 1ns/10ps
`include "sbc_defines.vh"

// What this block does
// - Clear-status zeroes event flags and four device event registers, not output queue.
// - Event-enable write stores eight-bit mask; query returns stored mask.
// - Event enable mask is zero after power-up.
// - Event bits: power-on, user, command, execution, device, query, control, complete.
// - Event-status query returns flags then clears them.
// - Service request mask write discards bits 6 and 7.
// - Service request mask read returns zero in bits 6 and 7.
// - Service request mask is zero at power-up.
// - Status byte: unused, master, event summary, message, four device summaries.
// - Status byte query never exceeds 127; bit 7 zero.
// - Event-status and status-byte replies never carry a header.
// - Other queries carry header only when headers are on.
// - Trigger command in external mode takes exactly one sample.
// - Judgment beep selects in-range, out-of-range or silent.
// - Key beep is a single on/off flag.
// - Enabling bin mode ends comparator mode.
// - Sub-display selects bin 1-14, second limits, references, or nothing.
// - Reference display in count mode is rejected with execution error.
// - Per-bin count limits, off or 0 to 999999.
// - Per-bin deviation limits, off or -999.99 to 999.99.
// - Limit query returns bin number, lower, upper.
// - Arguments arrive already rounded to stored precision.
module sbc_status_bin (
  input  wire        clk,            // 40 MHz clock
  input  wire        reset,          // Sync reset, active high
  input  wire        cmd_valid,      // One-cycle command strobe
  input  wire [3:0]  cmd_op,         // Command opcode
  input  wire [7:0]  cmd_arg,        // Numeric or coded argument
  input  wire        header_on,      // Header setting
  input  wire        count_mode,     // Judgment mode is count value
  input  wire        ext_trig_mode,  // External trigger selected
  input  wire        comp_active,    // Comparator measurement running
  input  wire [7:0]  event_set,      // Hardware event pulses
  input  wire [3:0]  dev_event_sum,  // Device register summaries
  input  wire        mav,            // Message available
  input  wire        lim_valid,      // Limit command strobe
  input  wire        lim_write,      // 1 write, 0 query
  input  wire        lim_kind,       // Count or deviation
  input  wire [3:0]  lim_bin,        // Bin number
  input  wire [20:0] lim_lower,      // Bit 20 off flag, low bits value
  input  wire [20:0] lim_upper,      // Bit 20 off flag, low bits value
  output reg         rsp_valid,      // One-cycle reply strobe
  output reg  [7:0]  rsp_data,       // Reply value
  output reg         rsp_header,     // Prefix header with reply
  output reg         lim_rsp_valid,  // One-cycle limit reply strobe
  output reg  [3:0]  lim_rsp_bin,    // Echoed bin number
  output reg  [20:0] lim_rsp_lower,  // Stored lower limit
  output reg  [20:0] lim_rsp_upper,  // Stored upper limit
  output reg         lim_rsp_error,  // Bin or value out of range
  output reg         dev_clear,      // Pulse clearing device registers
  output reg         sample_pulse,   // One sample request
  output reg         comp_stop,      // Pulse ending comparator mode
  output reg  [7:0]  event_flags,    // Standard event register
  output reg  [7:0]  status_byte,    // Status byte
  output reg  [1:0]  judgment_beep_select, // Judgment beep mode
  output reg         key_beep_select,      // Key beep flag
  output reg         bin_sort_enable,      // Bin measurement on
  output reg  [3:0]  bin_subdisplay_select,// Display code
  output reg  [1:0]  bin_subdisplay_kind   // Bin, ref1, ref2, other
);

  // Mask registers
  reg  [7:0]  event_enable_mask_q;
  reg  [7:0]  service_request_mask_q;
  // Per-bin limits, indexed by bin number
  reg  [20:0] cnt_lo_q [`SBC_BIN_MIN:`SBC_BIN_MAX];
  reg  [20:0] cnt_hi_q [`SBC_BIN_MIN:`SBC_BIN_MAX];
  reg  [20:0] dev_lo_q [`SBC_BIN_MIN:`SBC_BIN_MAX];
  reg  [20:0] dev_hi_q [`SBC_BIN_MIN:`SBC_BIN_MAX];

  // Command decode
  wire        do_op;
  wire        cls;
  wire        esr_read;
  wire        trg_cmd;
  wire        bin_on_cmd;
  wire        disp_write;
  wire        disp_coded;
  wire        disp_ref;
  wire        disp_bin_ok;
  wire        jbeep_ok;
  wire        exe_err;
  wire        hdr_query;
  wire        bare_query;

  // Event and status paths
  wire [7:0]  set_bits;
  wire [7:0]  exe_bit;
  wire        esb_d;
  wire [7:0]  sb_base;
  wire        mss_d;
  wire [7:0]  mss_bit;

  // Limit port decode
  wire        bin_ok;
  wire        cnt_lo_ok;
  wire        cnt_hi_ok;
  wire [17:0] dev_lo_val;
  wire [17:0] dev_hi_val;
  wire        dev_lo_ok;
  wire        dev_hi_ok;
  wire        lim_ok;
  wire        lim_store;
  wire        lim_query;
  integer     i;

  // Command strobes by opcode
  assign do_op      = cmd_valid;
  assign cls        = do_op && (cmd_op == `SBC_OP_CLS);
  assign esr_read   = do_op && (cmd_op == `SBC_OP_ESR_R);
  assign trg_cmd    = do_op && (cmd_op == `SBC_OP_TRG);
  assign bin_on_cmd = do_op && (cmd_op == `SBC_OP_BIN_W) && cmd_arg[0];
  assign disp_write = do_op && (cmd_op == `SBC_OP_DISP_W);

  // Display arg: bit 7 picks a coded choice, else a bin number
  assign disp_coded  = cmd_arg[7] && (cmd_arg[1:0] != `SBC_DSK_BIN);
  assign disp_ref    = (cmd_arg[1:0] == `SBC_DSK_REF1) || (cmd_arg[1:0] == `SBC_DSK_REF2);
  assign disp_bin_ok = !cmd_arg[7] && (cmd_arg[3:0] >= `SBC_BIN_MIN) && (cmd_arg[3:0] <= `SBC_DS_BIN_MAX);

  // Reference display needs deviation mode
  assign exe_err  = disp_write && count_mode && cmd_arg[7] && disp_ref;
  // Spare beep code is dropped silently
  assign jbeep_ok = (cmd_arg[1:0] != `SBC_JB_SPARE);

  // Queries that follow the header setting
  assign hdr_query  = do_op && ((cmd_op == `SBC_OP_ESE_R) || (cmd_op == `SBC_OP_SRE_R) ||
                      (cmd_op == `SBC_OP_JBEEP_R) || (cmd_op == `SBC_OP_KBEEP_R) ||
                      (cmd_op == `SBC_OP_BIN_R) || (cmd_op == `SBC_OP_DISP_R));
  // Queries that never carry a header
  assign bare_query = esr_read || (do_op && (cmd_op == `SBC_OP_SUM_R));

  // Hardware sets, with bits 6 and 1 blocked
  assign exe_bit  = {7'h00, exe_err} << `SBC_EV_EXE;
  assign set_bits = (event_set | exe_bit) & ~`SBC_NEVER_SET;
  // Summaries use registered flags, so they lag one cycle
  assign esb_d    = |(event_flags & event_enable_mask_q);
  assign sb_base  = {1'b0, 1'b0, esb_d, mav, dev_event_sum};
  assign mss_d    = |(sb_base & service_request_mask_q);
  assign mss_bit  = {7'h00, mss_d} << `SBC_SB_MSS;

  // Standard event flags; a set in the clearing cycle wins
  always @(posedge clk) begin
    if (reset) begin
      event_flags <= `SBC_ZERO8;
    end else if (cls || esr_read) begin
      event_flags <= set_bits;
    end else begin
      event_flags <= event_flags | set_bits;
    end
  end

  // Status byte, master summary from masked byte
  always @(posedge clk) begin
    if (reset) begin
      status_byte <= `SBC_ZERO8;
    end else begin
      status_byte <= sb_base | mss_bit;
    end
  end

  // Event enable mask
  always @(posedge clk) begin
    if (reset) begin
      event_enable_mask_q <= `SBC_ZERO8;
    end else if (do_op && (cmd_op == `SBC_OP_ESE_W)) begin
      event_enable_mask_q <= cmd_arg;
    end
  end

  // Service request mask; top two bits never stored
  always @(posedge clk) begin
    if (reset) begin
      service_request_mask_q <= `SBC_ZERO8;
    end else if (do_op && (cmd_op == `SBC_OP_SRE_W)) begin
      service_request_mask_q <= cmd_arg & `SBC_SRE_KEEP;
    end
  end

  // Judgment beep; spare code keeps the old setting
  always @(posedge clk) begin
    if (reset) begin
      judgment_beep_select <= `SBC_JB_OFF;
    end else if (do_op && (cmd_op == `SBC_OP_JBEEP_W) && jbeep_ok) begin
      judgment_beep_select <= cmd_arg[1:0];
    end
  end

  // Key beep flag, on after reset
  always @(posedge clk) begin
    if (reset) begin
      key_beep_select <= 1'b1;
    end else if (do_op && (cmd_op == `SBC_OP_KBEEP_W)) begin
      key_beep_select <= cmd_arg[0];
    end
  end

  // Bin measurement enable
  always @(posedge clk) begin
    if (reset) begin
      bin_sort_enable <= 1'b0;
    end else if (do_op && (cmd_op == `SBC_OP_BIN_W)) begin
      bin_sort_enable <= cmd_arg[0];
    end
  end

  // Sub-display choice; a refused or unknown code leaves it alone
  always @(posedge clk) begin
    if (reset) begin
      bin_subdisplay_select <= `SBC_DS_OFF;
      bin_subdisplay_kind   <= `SBC_DSK_OTHER;
    end else if (disp_write && disp_coded && !exe_err) begin
      bin_subdisplay_kind <= cmd_arg[1:0];
      if ((cmd_arg[1:0] == `SBC_DSK_OTHER) && cmd_arg[2]) begin
        bin_subdisplay_select <= `SBC_DS_SECOND;
      end else begin
        bin_subdisplay_select <= `SBC_DS_OFF;
      end
    end else if (disp_write && disp_bin_ok) begin
      bin_subdisplay_kind   <= `SBC_DSK_BIN;
      bin_subdisplay_select <= cmd_arg[3:0];
    end
  end

  // Device register clear pulse
  always @(posedge clk) begin
    if (reset) begin
      dev_clear <= 1'b0;
    end else begin
      dev_clear <= cls;
    end
  end

  // One sample per trigger, external mode only
  always @(posedge clk) begin
    if (reset) begin
      sample_pulse <= 1'b0;
    end else begin
      sample_pulse <= trg_cmd && ext_trig_mode;
    end
  end

  // Comparator stop when bin mode starts
  always @(posedge clk) begin
    if (reset) begin
      comp_stop <= 1'b0;
    end else begin
      comp_stop <= bin_on_cmd && comp_active;
    end
  end

  // Reply strobe
  always @(posedge clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= hdr_query || bare_query;
    end
  end

  // Header flag, never on the bare queries
  always @(posedge clk) begin
    if (reset) begin
      rsp_header <= 1'b0;
    end else begin
      rsp_header <= hdr_query && header_on;
    end
  end

  // Reply value; holds between replies
  always @(posedge clk) begin
    if (reset) begin
      rsp_data <= `SBC_ZERO8;
    end else if (do_op) begin
      case (cmd_op)
        `SBC_OP_ESE_R:   rsp_data <= event_enable_mask_q;
        `SBC_OP_ESR_R:   rsp_data <= event_flags;
        `SBC_OP_SRE_R:   rsp_data <= service_request_mask_q & `SBC_SRE_KEEP;
        `SBC_OP_SUM_R:   rsp_data <= status_byte;
        `SBC_OP_JBEEP_R: rsp_data <= {6'h00, judgment_beep_select};
        `SBC_OP_KBEEP_R: rsp_data <= {7'h00, key_beep_select};
        `SBC_OP_BIN_R:   rsp_data <= {7'h00, bin_sort_enable};
        `SBC_OP_DISP_R:  rsp_data <= {2'h0, bin_subdisplay_kind, bin_subdisplay_select};
        default: ;
      endcase
    end
  end

  // Bin number range
  assign bin_ok = (lim_bin >= `SBC_BIN_MIN) && (lim_bin <= `SBC_BIN_MAX);
  // Count limits: off, or 0 to 999999
  assign cnt_lo_ok = lim_lower[`SBC_LIM_OFF_BIT] || (lim_lower[`SBC_CNT_HI:0] <= `SBC_CNT_MAX);
  assign cnt_hi_ok = lim_upper[`SBC_LIM_OFF_BIT] || (lim_upper[`SBC_CNT_HI:0] <= `SBC_CNT_MAX);
  // Hundredths; 99999 needs eighteen signed bits
  assign dev_lo_val = lim_lower[`SBC_DEV_HI:0];
  assign dev_hi_val = lim_upper[`SBC_DEV_HI:0];
  assign dev_lo_ok  = lim_lower[`SBC_LIM_OFF_BIT] ||
                      (($signed(dev_lo_val) >= `SBC_DEV_MIN) && ($signed(dev_lo_val) <= `SBC_DEV_MAX));
  assign dev_hi_ok  = lim_upper[`SBC_LIM_OFF_BIT] ||
                      (($signed(dev_hi_val) >= `SBC_DEV_MIN) && ($signed(dev_hi_val) <= `SBC_DEV_MAX));
  // Values arrive pre-rounded, so only range is checked
  assign lim_ok    = (lim_kind == `SBC_LIM_CNT) ? (cnt_lo_ok && cnt_hi_ok) : (dev_lo_ok && dev_hi_ok);
  // Out-of-range writes are dropped whole
  assign lim_store = lim_valid && lim_write && bin_ok && lim_ok;
  assign lim_query = lim_valid && !lim_write && bin_ok;

  // Count-mode limits, all off after reset
  always @(posedge clk) begin
    if (reset) begin
      for (i = `SBC_BIN_MIN; i <= `SBC_BIN_MAX; i = i + 1) begin
        cnt_lo_q[i] <= {1'b1, 20'h0_0000};
        cnt_hi_q[i] <= {1'b1, 20'h0_0000};
      end
    end else if (lim_store && (lim_kind == `SBC_LIM_CNT)) begin
      cnt_lo_q[lim_bin] <= lim_lower;
      cnt_hi_q[lim_bin] <= lim_upper;
    end
  end

  // Deviation limits, stored apart from count limits
  always @(posedge clk) begin
    if (reset) begin
      for (i = `SBC_BIN_MIN; i <= `SBC_BIN_MAX; i = i + 1) begin
        dev_lo_q[i] <= {1'b1, 20'h0_0000};
        dev_hi_q[i] <= {1'b1, 20'h0_0000};
      end
    end else if (lim_store && (lim_kind == `SBC_LIM_DEV)) begin
      dev_lo_q[lim_bin] <= lim_lower;
      dev_hi_q[lim_bin] <= lim_upper;
    end
  end

  // Limit reply strobe
  always @(posedge clk) begin
    if (reset) begin
      lim_rsp_valid <= 1'b0;
    end else begin
      lim_rsp_valid <= lim_query;
    end
  end

  // Bad bin or refused write
  always @(posedge clk) begin
    if (reset) begin
      lim_rsp_error <= 1'b0;
    end else begin
      lim_rsp_error <= lim_valid && (!bin_ok || (lim_write && !lim_ok));
    end
  end

  // Echoed bin number
  always @(posedge clk) begin
    if (reset) begin
      lim_rsp_bin <= 4'h0;
    end else if (lim_query) begin
      lim_rsp_bin <= lim_bin;
    end
  end

  // Stored lower limit
  always @(posedge clk) begin
    if (reset) begin
      lim_rsp_lower <= `SBC_ZERO21;
    end else if (lim_query) begin
      lim_rsp_lower <= (lim_kind == `SBC_LIM_CNT) ? cnt_lo_q[lim_bin] : dev_lo_q[lim_bin];
    end
  end

  // Stored upper limit
  always @(posedge clk) begin
    if (reset) begin
      lim_rsp_upper <= `SBC_ZERO21;
    end else if (lim_query) begin
      lim_rsp_upper <= (lim_kind == `SBC_LIM_CNT) ? cnt_hi_q[lim_bin] : dev_hi_q[lim_bin];
    end
  end

endmodule // sbc_status_bin

// ===== sbc_checker_assertions.sv
// Concurrent checks on the status and bin command handler ports
`timescale 1ns/10ps
`include "sbc_defines.vh"
module sbc_checker (
  input wire       clk,           // Clock
  input wire       reset,         // Sync reset
  input wire       cmd_valid,     // Command strobe
  input wire [3:0] cmd_op,        // Opcode
  input wire [7:0] cmd_arg,       // Argument
  input wire       ext_trig_mode, // External trigger
  input wire       comp_active,   // Comparator running
  input wire [7:0] event_set,     // Event pulses
  input wire       lim_valid,     // Limit strobe
  input wire [3:0] lim_bin,       // Bin number
  input wire       rsp_valid,     // Reply strobe
  input wire [7:0] rsp_data,      // Reply value
  input wire       rsp_header,    // Header flag
  input wire       lim_rsp_error, // Limit error
  input wire       dev_clear,     // Device clear
  input wire       sample_pulse,  // Sample request
  input wire       comp_stop,     // Comparator stop
  input wire [7:0] event_flags    // Event register
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Commands with no event pulse alongside, so flag values are exact
  wire quiet = cmd_valid && (event_set == 8'h00);
  property p_esr; quiet && cmd_op == `SBC_OP_ESR_R |=> rsp_valid && !rsp_header && rsp_data == $past(event_flags) && event_flags == 8'h00; endproperty
  a_esr: assert property (p_esr) else $error("event read reply or clear wrong");
  property p_sbyte; quiet && cmd_op == `SBC_OP_SUM_R |=> rsp_valid && !rsp_header && !rsp_data[7]; endproperty
  a_sbyte: assert property (p_sbyte) else $error("status byte reply wrong");
  property p_cls; quiet && cmd_op == `SBC_OP_CLS |=> event_flags == 8'h00 ##[0:1] dev_clear; endproperty
  a_cls: assert property (p_cls) else $error("clear status incomplete");
  property p_sre; cmd_valid && cmd_op == `SBC_OP_SRE_R |=> rsp_valid && rsp_data[7:6] == 2'b00; endproperty
  a_sre: assert property (p_sre) else $error("service mask top bits set");
  property p_trg; cmd_valid && cmd_op == `SBC_OP_TRG |=> sample_pulse == $past(ext_trig_mode); endproperty
  a_trg: assert property (p_trg) else $error("sample request wrong");
  property p_comp; cmd_valid && cmd_op == `SBC_OP_BIN_W && cmd_arg[0] && comp_active |=> comp_stop; endproperty
  a_comp: assert property (p_comp) else $error("comparator not stopped");
  property p_never; (event_flags & `SBC_NEVER_SET) == 8'h00; endproperty
  a_never: assert property (p_never) else $error("unused event bit set");
  property p_lim; lim_valid && (lim_bin == 4'h0 || lim_bin > 4'hE) |=> lim_rsp_error; endproperty
  a_lim: assert property (p_lim) else $error("bad bin not refused");
  // Main scenarios seen
  c_esr: cover property (quiet && cmd_op == `SBC_OP_ESR_R && event_flags != 8'h00);
  c_trg: cover property (cmd_valid && cmd_op == `SBC_OP_TRG && ext_trig_mode);
  c_lim: cover property (lim_valid && lim_bin > 4'hE);
endmodule // sbc_checker
bind sbc_status_bin sbc_checker u_chk (.clk, .reset, .cmd_valid, .cmd_op, .cmd_arg, .ext_trig_mode, .comp_active,
  .event_set, .lim_valid, .lim_bin, .rsp_valid, .rsp_data, .rsp_header, .lim_rsp_error, .dev_clear,
  .sample_pulse, .comp_stop, .event_flags);

// ===== sbc_host.sv
// Remote host model issuing commands and limit requests
`timescale 1ns/10ps
module sbc_host (
  input  wire         clk,              // Bench clock
  output logic        cmd_valid = 1'b0, // Command strobe
  output logic [3:0]  cmd_op = 4'h0,    // Opcode
  output logic [7:0]  cmd_arg = 8'h00,  // Argument
  output logic        lim_valid = 1'b0, // Limit strobe
  output logic        lim_write = 1'b0, // Write or query
  output logic        lim_kind = 1'b0,  // Count or deviation
  output logic [3:0]  lim_bin = 4'h0,   // Bin number
  output logic [20:0] lim_lower = 0,    // Lower limit
  output logic [20:0] lim_upper = 0     // Upper limit
);
  // One-cycle command; idle lines then show the inverse, never a stale value
  task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
    @(negedge clk);
    cmd_op = op;
    cmd_arg = arg;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_op = ~op;
    cmd_arg = ~arg;
  endtask
  // One-cycle limit request, values already rounded to stored precision
  task automatic lim(input logic w, input logic k, input logic [3:0] b, input logic [20:0] lo, input logic [20:0] up);
    @(negedge clk);
    {lim_write, lim_kind, lim_bin} = {w, k, b};
    {lim_lower, lim_upper} = {lo, up};
    lim_valid = 1'b1;
    @(negedge clk);
    lim_valid = 1'b0;
    {lim_bin, lim_lower, lim_upper} = ~{b, lo, up};
  endtask
endmodule // sbc_host

// ===== sbc_status_bin_tb.sv
// Self-checking bench for the status and bin command handler
`timescale 1ns/10ps
`include "sbc_defines.vh"
module sbc_status_bin_tb;
  logic        clk, reset, header_on, count_mode, ext_trig_mode, comp_active, mav;
  logic [7:0]  event_set, r;
  logic [3:0]  dev_event_sum;
  logic [20:0] lo;
  wire         cmd_valid, lim_valid, lim_write, lim_kind, rsp_valid, rsp_header, lim_rsp_valid, lim_rsp_error;
  wire         dev_clear, sample_pulse, comp_stop, key_beep_select, bin_sort_enable;
  wire  [3:0]  cmd_op, lim_bin, lim_rsp_bin, bin_subdisplay_select;
  wire  [7:0]  cmd_arg, rsp_data, event_flags, status_byte;
  wire  [1:0]  judgment_beep_select, bin_subdisplay_kind;
  wire  [20:0] lim_lower, lim_upper, lim_rsp_lower, lim_rsp_upper;
  logic [8:0]  rq[$];
  logic [45:0] lq[$];
  int          bad_count = 0;
  int          samples_checked = 0;
  int          n_samp = 0;
  int          n_err = 0;
  logic [7:0]  da [4] = '{8'h0E, 8'h01, 8'h87, 8'h83};
  logic [5:0]  dx [4] = '{6'h38, 6'h04, 6'h3F, 6'h03};

  sbc_host host (.clk, .cmd_valid, .cmd_op, .cmd_arg, .lim_valid, .lim_write, .lim_kind, .lim_bin, .lim_lower,
    .lim_upper);
  sbc_status_bin dut (.clk, .reset, .cmd_valid, .cmd_op, .cmd_arg, .header_on, .count_mode, .ext_trig_mode,
    .comp_active, .event_set, .dev_event_sum, .mav, .lim_valid, .lim_write, .lim_kind, .lim_bin, .lim_lower,
    .lim_upper, .rsp_valid, .rsp_data, .rsp_header, .lim_rsp_valid, .lim_rsp_bin, .lim_rsp_lower, .lim_rsp_upper,
    .lim_rsp_error, .dev_clear, .sample_pulse, .comp_stop, .event_flags, .status_byte, .judgment_beep_select,
    .key_beep_select, .bin_sort_enable, .bin_subdisplay_select, .bin_subdisplay_kind);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Note the reply first, then send the query
  task automatic q(input logic [3:0] op, input logic [7:0] d, input logic h);
    rq.push_back({h, d});
    host.cmd(op, 8'h00);
  endtask

  task automatic lq_q(input logic k, input logic [3:0] b, input logic [20:0] l, input logic [20:0] u);
    lq.push_back({b, l, u});
    host.lim(1'b0, k, b, 21'h00_0000, 21'h00_0000);
  endtask

  // Watcher samples just after the edge, once replies have settled
  always @(posedge clk) begin
    #1;
    if (sample_pulse === 1'b1) n_samp++;
    if (lim_rsp_error === 1'b1) n_err++;
    if (rsp_valid === 1'b1) begin
      if (rq.size() == 0) chk("reply count", 0, 1);
      else chk("reply", rq.pop_front(), {rsp_header, rsp_data});
    end
    if (lim_rsp_valid === 1'b1) begin
      if (lq.size() == 0) chk("limit reply count", 0, 1);
      else chk("limit reply", lq.pop_front(), {lim_rsp_bin, lim_rsp_lower, lim_rsp_upper});
    end
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    close_out();
  end

  initial begin
    r = $urandom(32'h098d);
    {reset, header_on, count_mode, ext_trig_mode, comp_active, mav} = 6'b110000;
    event_set = 8'h00;
    dev_event_sum = 4'h0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    chk("key beep", 1, key_beep_select);
    chk("judgment beep", `SBC_JB_OFF, judgment_beep_select);
    q(`SBC_OP_ESE_R, 8'h00, 1'b1);
    q(`SBC_OP_SRE_R, 8'h00, 1'b1);
    // Mask round trips under both header settings
    for (int h = 0; h < 2; h++) begin
      header_on = h[0];
      r = $urandom;
      host.cmd(`SBC_OP_ESE_W, r);
      q(`SBC_OP_ESE_R, r, h[0]);
      host.cmd(`SBC_OP_SRE_W, r | 8'hC0);
      q(`SBC_OP_SRE_R, r & `SBC_SRE_KEEP, h[0]);
    end
    // Every event bit pulsed; the unused ones stay clear
    event_set = 8'hFF;
    @(negedge clk);
    event_set = 8'h00;
    @(negedge clk);
    chk("event flags", 8'hBD, event_flags);
    q(`SBC_OP_ESR_R, 8'hBD, 1'b0);
    q(`SBC_OP_ESR_R, 8'h00, 1'b0);
    // Summary bits of the status byte
    host.cmd(`SBC_OP_ESE_W, 8'h20);
    host.cmd(`SBC_OP_SRE_W, 8'h20);
    {dev_event_sum, mav, event_set} = {4'h5, 1'b1, 8'h20};
    @(negedge clk);
    event_set = 8'h00;
    repeat (3) @(negedge clk);
    q(`SBC_OP_SUM_R, 8'h75, 1'b0);
    host.cmd(`SBC_OP_SRE_W, 8'h02);
    repeat (2) @(negedge clk);
    q(`SBC_OP_SUM_R, 8'h35, 1'b0);
    // Clear status keeps the message flag
    host.cmd(`SBC_OP_CLS, 8'h00);
    chk("flags after clear", 8'h00, event_flags);
    dev_event_sum = 4'h0;
    repeat (2) @(negedge clk);
    q(`SBC_OP_SUM_R, 8'h10, 1'b0);
    for (int e = 0; e < 2; e++) begin
      ext_trig_mode = e[0];
      host.cmd(`SBC_OP_TRG, 8'h00);
    end
    chk("sample count", 1, n_samp);
    // Beep codes, the spare code is ignored
    for (int b = 0; b < 4; b++) begin
      host.cmd(`SBC_OP_JBEEP_W, b[7:0]);
      host.cmd(`SBC_OP_KBEEP_W, b[7:0]);
      chk("judgment beep", (b == 3) ? 2'h2 : b[1:0], judgment_beep_select);
      chk("key beep", b[0], key_beep_select);
    end
    comp_active = 1'b1;
    host.cmd(`SBC_OP_BIN_W, 8'h01);
    chk("bin enable", 1, bin_sort_enable);
    for (int i = 0; i < 4; i++) begin
      host.cmd(`SBC_OP_DISP_W, da[i]);
      chk("display", dx[i], {bin_subdisplay_select, bin_subdisplay_kind});
    end
    host.cmd(`SBC_OP_DISP_W, 8'h82);
    chk("display kind", `SBC_DSK_REF2, bin_subdisplay_kind);
    count_mode = 1'b1;
    host.cmd(`SBC_OP_DISP_W, 8'h81);
    chk("display kind", `SBC_DSK_REF2, bin_subdisplay_kind);
    chk("execution error", 1, event_flags[`SBC_EV_EXE]);
    // Limits per bin, count and deviation stored apart, over-range write dropped
    lo = $urandom % 1000000;
    host.lim(1'b1, `SBC_LIM_CNT, 4'h1, lo, 21'h0F_423F);
    host.lim(1'b1, `SBC_LIM_DEV, 4'h1, 21'h00_0000, 21'h01_869F);
    host.lim(1'b1, `SBC_LIM_CNT, 4'hE, 21'h10_0000, 21'h00_0000);
    host.lim(1'b1, `SBC_LIM_CNT, 4'hE, 21'h00_0000, 21'h0F_4240);
    lq_q(`SBC_LIM_CNT, 4'h1, lo, 21'h0F_423F);
    lq_q(`SBC_LIM_DEV, 4'h1, 21'h00_0000, 21'h01_869F);
    lq_q(`SBC_LIM_CNT, 4'hE, 21'h10_0000, 21'h00_0000);
    host.lim(1'b0, `SBC_LIM_CNT, 4'hF, 21'h00_0000, 21'h00_0000);
    repeat (4) @(negedge clk);
    chk("limit errors", 2, n_err);
    chk("pending replies", 0, rq.size() + lq.size());
    close_out();
  end
endmodule // sbc_status_bin_tb
